// File: logic/fps_params.svh
// Timing and count constants for the fault-protection sequencer
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH
`define FPS_CLK_MHZ 100
`define FPS_OC_LOW_MS 15
`define FPS_OC_HIGH_MS 10
`define FPS_HICCUP_MS 480
`define FPS_BLANK_LATCH_MS 1
`define FPS_RAMP_MS 10
`define FPS_DECAY_MS 1
`define FPS_MS_CYCLES (`FPS_CLK_MHZ * 1000)
`define FPS_SC_LIMIT 4'hA
`define FPS_SYNC_IDLE 8'h18
`endif

// File: logic/fps_pkg.sv
// Types for the fault-protection sequencer
`default_nettype none
package fps_pkg;
    typedef enum logic [5:0] {
        FPS_RAMP = 6'b00_0001,
        FPS_RUN = 6'b00_0010,
        FPS_HICCUP = 6'b00_0100,
        FPS_BLANK = 6'b00_1000,
        FPS_LATCH = 6'b01_0000,
        FPS_UV = 6'b10_0000
    } fps_state_type;
endpackage
`default_nettype wire

// File: logic/fps_sequencer.sv
// Fault-protection sequencer top level
`timescale 1ns/10ps
`default_nettype none
`include "fps_params.svh"
module fps_sequencer #(
    parameter int unsigned MS_CYCLES = `FPS_MS_CYCLES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic protection_response_select,
    input wire logic oc_low_cmp_in,
    input wire logic oc_high_cmp_in,
    input wire logic short_circuit_in,
    input wire logic feedback_in,
    input wire logic bus_overvoltage_in,
    input wire logic bus_undervoltage_in,
    input wire logic cycle_end_in,
    output logic fault_flag_out,
    output logic rampup_done_out,
    output logic switching_enable_out,
    output logic softstart_restart_out,
    output logic overcurrent_protection_out,
    output logic bus_overvoltage_protection_out
);
    import fps_pkg::*;

    localparam int unsigned OCL_CYC = `FPS_OC_LOW_MS * MS_CYCLES;
    localparam int unsigned OCH_CYC = `FPS_OC_HIGH_MS * MS_CYCLES;
    localparam logic [31:0] HIC_CYC = 32'(`FPS_HICCUP_MS * MS_CYCLES);
    localparam logic [31:0] BLL_CYC = 32'(`FPS_BLANK_LATCH_MS * MS_CYCLES);
    localparam logic [31:0] RMP_CYC = 32'(`FPS_RAMP_MS * MS_CYCLES);
    localparam logic [31:0] DEC_CYC = 32'(`FPS_DECAY_MS * MS_CYCLES);

    // ----------------------------------------
    // Reset release and input synchronisers
    // ----------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [7:0] in_meta_q;
    logic [7:0] in_sync_q;
    logic sel;
    logic oc_lo;
    logic oc_hi;
    logic sc_ok;
    logic fb_hi;
    logic ov;
    logic uv;
    logic cyc_end;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // Rest at idle levels so reset shows no false short
            in_meta_q <= `FPS_SYNC_IDLE;
            in_sync_q <= `FPS_SYNC_IDLE;
        end else begin
            in_meta_q <= {protection_response_select, oc_low_cmp_in,
                oc_high_cmp_in, short_circuit_in, feedback_in,
                bus_overvoltage_in, bus_undervoltage_in, cycle_end_in};
            in_sync_q <= in_meta_q;
        end
    end
    assign {sel, oc_lo, oc_hi, sc_ok, fb_hi, ov, uv, cyc_end} = in_sync_q;

    // ----------------------------------------
    // Over-current trip timers
    // ----------------------------------------
    logic ocl_trip;
    logic och_trip;
    logic oc_trip;

    fps_trip_timer #(.LIMIT(OCL_CYC)) u_ocl (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cond(oc_lo),
        .expired(ocl_trip)
    );
    fps_trip_timer #(.LIMIT(OCH_CYC)) u_och (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cond(oc_hi),
        .expired(och_trip)
    );
    assign oc_trip = ocl_trip || och_trip;

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    fps_state_type state_q, state_d;
    logic [31:0] tmr_q, tmr_d;
    logic [3:0] sc_cnt_q, sc_cnt_d;
    logic started_q, started_d;
    logic run_q, run_d;
    logic restart_q, restart_d;
    logic fault_q, fault_d;
    logic sc_evt;
    logic both_hi;

    assign both_hi = fb_hi && sc_ok;
    // Low on the synchronised short input is the short event
    assign sc_evt = !sc_ok;

    always_comb begin
        state_d = state_q;
        tmr_d = tmr_q;
        sc_cnt_d = sc_cnt_q;
        started_d = started_q;
        run_d = run_q;
        restart_d = 1'b0;
        fault_d = fault_q;
        case (state_q)
            FPS_RAMP: begin
                run_d = 1'b1;
                tmr_d = tmr_q + 32'h0000_0001;
                if (sc_evt && !fb_hi) begin
                    run_d = 1'b0;
                    tmr_d = 32'h0000_0000;
                    state_d = FPS_BLANK;
                    if (!sel) begin
                        sc_cnt_d = sc_cnt_q + 4'h1;
                    end
                end else if (tmr_q >= RMP_CYC - 32'h0000_0001) begin
                    started_d = 1'b1;
                    tmr_d = 32'h0000_0000;
                    state_d = FPS_RUN;
                end
            end
            FPS_RUN: begin
                // Drop out at cycle end on low feedback
                if (!fb_hi && cyc_end) begin
                    run_d = 1'b0;
                end else if (fb_hi) begin
                    run_d = 1'b1;
                end
                tmr_d = tmr_q + 32'h0000_0001;
                if (tmr_q >= DEC_CYC - 32'h0000_0001) begin
                    tmr_d = 32'h0000_0000;
                    if (sc_cnt_q != 4'h0) begin
                        sc_cnt_d = sc_cnt_q - 4'h1;
                    end
                end
                if (sc_evt) begin
                    run_d = 1'b0;
                    tmr_d = 32'h0000_0000;
                    state_d = FPS_BLANK;
                    if (!sel) begin
                        sc_cnt_d = sc_cnt_q + 4'h1;
                    end
                end else if (oc_trip) begin
                    run_d = 1'b0;
                    tmr_d = 32'h0000_0000;
                    state_d = sel ? FPS_HICCUP : FPS_LATCH;
                end
            end
            FPS_HICCUP: begin
                run_d = 1'b0;
                if (tmr_q < HIC_CYC) begin
                    tmr_d = tmr_q + 32'h0000_0001;
                end else if (both_hi) begin
                    tmr_d = 32'h0000_0000;
                    restart_d = 1'b1;
                    state_d = FPS_RAMP;
                end
            end
            FPS_BLANK: begin
                run_d = 1'b0;
                if (tmr_q < (sel ? HIC_CYC : BLL_CYC)) begin
                    tmr_d = tmr_q + 32'h0000_0001;
                end else if (both_hi) begin
                    tmr_d = 32'h0000_0000;
                    restart_d = 1'b1;
                    state_d = FPS_RAMP;
                end
            end
            FPS_UV: begin
                run_d = 1'b0;
                if (!uv) begin
                    tmr_d = 32'h0000_0000;
                    restart_d = 1'b1;
                    state_d = FPS_RAMP;
                end
            end
            FPS_LATCH: begin
                run_d = 1'b0;
                fault_d = 1'b1;
            end
            default: begin
                state_d = FPS_LATCH;
            end
        endcase
        if (!sel && sc_cnt_d >= `FPS_SC_LIMIT) begin
            state_d = FPS_LATCH;
        end
        // Bus checks in every state but LATCH, over-voltage latches
        if (state_q != FPS_LATCH) begin
            if (ov) begin
                run_d = 1'b0;
                state_d = FPS_LATCH;
            end else if (uv && state_d != FPS_LATCH) begin
                run_d = 1'b0;
                restart_d = 1'b0;
                state_d = FPS_UV;
            end
        end
        if (state_d == FPS_LATCH) begin
            fault_d = 1'b1;
            run_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= FPS_RAMP;
            tmr_q <= 32'h0000_0000;
            sc_cnt_q <= 4'h0;
            started_q <= 1'b0;
            run_q <= 1'b0;
            restart_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            sc_cnt_q <= sc_cnt_d;
            started_q <= started_d;
            run_q <= run_d;
            restart_q <= restart_d;
            fault_q <= fault_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Ramp-done high after first ramp, low in blanking, hiccup and latch
    assign rampup_done_out = started_q && !(state_q inside {FPS_BLANK,
        FPS_HICCUP, FPS_LATCH});
    assign fault_flag_out = fault_q;
    assign switching_enable_out = run_q;
    assign softstart_restart_out = restart_q;
    assign overcurrent_protection_out = oc_trip;
    assign bus_overvoltage_protection_out = ov;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_latch_holds: assert property (
        state_q == FPS_LATCH |=> state_q == FPS_LATCH && fault_flag_out
            && !rampup_done_out && !switching_enable_out)
        else $error("latched state left or outputs wrong");
    a_ov_latches: assert property (
        ov && state_q != FPS_LATCH |=> state_q == FPS_LATCH)
        else $error("over-voltage did not latch");
    a_uv_no_latch: assert property (
        uv && !ov && state_q == FPS_RUN && !sc_evt && !oc_trip
            && sc_cnt_q < `FPS_SC_LIMIT |=> state_q == FPS_UV)
        else $error("under-voltage handled wrongly");
    a_hiccup_flag: assert property (
        state_q == FPS_HICCUP |-> !fault_flag_out && !switching_enable_out)
        else $error("hiccup shows fault or switches");
    a_oc_response: assert property (
        state_q == FPS_RUN && oc_trip && !sc_evt && !ov && !uv
            && sel |=> state_q == FPS_HICCUP)
        else $error("over-current hiccup not entered");
    a_ramp_done_low: assert property (
        state_q == FPS_BLANK || state_q == FPS_HICCUP |-> !rampup_done_out)
        else $error("ramp-done high while not switching");
    a_blank_extend: assert property (
        state_q == FPS_BLANK && !both_hi |=> state_q != FPS_RAMP)
        else $error("blanking ended with inputs low");
    a_fault_sticky: assert property (
        $rose(fault_flag_out) |=> fault_flag_out [*8])
        else $error("fault flag dropped");
    a_abort_ramp: assert property (
        state_q == FPS_RAMP && sc_evt && !fb_hi && !ov |=>
            state_q == FPS_BLANK || state_q == FPS_LATCH
            || state_q == FPS_UV)
        else $error("ramp not aborted");

    c_hiccup: cover property (state_q == FPS_HICCUP ##1 state_q == FPS_RAMP);
    c_blank: cover property (state_q == FPS_BLANK ##1 state_q == FPS_RAMP);
    c_latch: cover property ($rose(fault_flag_out));
    c_run: cover property ($rose(rampup_done_out));
endmodule
`default_nettype wire

// File: logic/fps_trip_timer.sv
// Trip-delay timer: counts while a condition holds, restarts when it drops
`timescale 1ns/10ps
`default_nettype none
module fps_trip_timer #(
    parameter int unsigned LIMIT = 100
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cond,
    output logic expired
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (!cond) begin
            cnt_d = 32'h0000_0000;
        end else if (cnt_q < LIMIT) begin
            cnt_d = cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign expired = cond && (cnt_q >= LIMIT);
endmodule
`default_nettype wire

// File: test/fps_stage_model.sv
// Power-stage model: feedback, short pull-down and cycle-end marks
`timescale 1ns/10ps
`default_nettype none
module fps_stage_model (
    input wire logic clk_sys,
    input wire logic switching_enable_out,
    input wire logic short_cmd,
    input wire logic fb_low_cmd,
    output logic short_circuit_in,
    output logic feedback_in,
    output logic cycle_end_in
);
    logic [2:0] phase;
    // A shorted output turns the sense transistor on: both lines go low
    assign short_circuit_in = !short_cmd;
    assign feedback_in = !(short_cmd || fb_low_cmd);
    // Cycle ends come only while the stage is switching
    always @(negedge clk_sys) begin
        phase <= switching_enable_out ? phase + 3'h1 : 3'h0;
        cycle_end_in <= switching_enable_out && phase == 3'h7;
    end
endmodule
`default_nettype wire

// File: test/test_fps_sequencer.sv
// Self-checking bench for the fault-protection sequencer
`timescale 1ns/10ps
`default_nettype none
`include "fps_params.svh"
module test_fps_sequencer;
    localparam int MS = 10;
    logic clk_sys, nrst, resp_sel, oc_low, oc_high, bus_ov, bus_uv;
    logic short_cmd, fb_low_cmd, short_circuit_in, feedback_in;
    logic cycle_end_in, fault_flag_out, rampup_done_out;
    logic switching_enable_out, softstart_restart_out, ocp_out, ovp_out;
    int n_mismatch, n_checks, n;

    // ----------------------------------------
    // Design and far side
    // ----------------------------------------
    fps_sequencer #(.MS_CYCLES(MS)) u_dut (
        .clk_sys(clk_sys), .nrst(nrst),
        .protection_response_select(resp_sel),
        .oc_low_cmp_in(oc_low), .oc_high_cmp_in(oc_high),
        .short_circuit_in(short_circuit_in), .feedback_in(feedback_in),
        .bus_overvoltage_in(bus_ov), .bus_undervoltage_in(bus_uv),
        .cycle_end_in(cycle_end_in), .fault_flag_out(fault_flag_out),
        .rampup_done_out(rampup_done_out),
        .switching_enable_out(switching_enable_out),
        .softstart_restart_out(softstart_restart_out),
        .overcurrent_protection_out(ocp_out),
        .bus_overvoltage_protection_out(ovp_out)
    );
    fps_stage_model u_stage (
        .clk_sys(clk_sys), .switching_enable_out(switching_enable_out),
        .short_cmd(short_cmd), .fb_low_cmd(fb_low_cmd),
        .short_circuit_in(short_circuit_in), .feedback_in(feedback_in),
        .cycle_end_in(cycle_end_in)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic int cyc(input int ms);
        return ms * MS;
    endfunction

    function automatic logic pick(input int which);
        case (which)
            0: return switching_enable_out;
            1: return rampup_done_out;
            2: return softstart_restart_out;
            default: return fault_flag_out;
        endcase
    endfunction

    task automatic chk(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_rng(input string name, input int lo, input int hi,
                           input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi,
                     got);
        end
    endtask

    task automatic wait_sig(input int which, input logic v, input int lim,
                            output int cnt);
        cnt = 0;
        while (pick(which) !== v && cnt < lim) begin
            @(negedge clk_sys);
            cnt++;
        end
        chk("output_reached", v, pick(which));
    endtask

    task automatic cycles(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    task automatic power_up(input logic mode);
        nrst = 1'b0;
        resp_sel = mode;
        {oc_low, oc_high, bus_ov, bus_uv, short_cmd, fb_low_cmd} = 6'h00;
        cycles(20);
        nrst = 1'b1;
    endtask

    task automatic test_done;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = !clk_sys;
    end

    initial begin
        repeat (80000) @(posedge clk_sys);
        n_mismatch++;
        test_done();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        n_mismatch = 0;
        n_checks = 0;
        void'($urandom(7393));
        power_up(1'b0);
        cycles(50);
        chk("rampup_early", 1'b0, rampup_done_out);
        wait_sig(1, 1'b1, 120, n);
        bus_uv = 1'b1;
        wait_sig(0, 1'b0, 10, n);
        chk("uv_fault", 1'b0, fault_flag_out);
        chk("uv_done_kept", 1'b1, rampup_done_out);
        bus_uv = 1'b0;
        wait_sig(2, 1'b1, 20, n);
        cycles(cyc(`FPS_RAMP_MS) + 4);
        chk("uv_ramp_done", 1'b1, rampup_done_out);
        fb_low_cmd = 1'b1;
        wait_sig(0, 1'b0, 30, n);
        fb_low_cmd = 1'b0;
        wait_sig(0, 1'b1, 10, n);
        short_cmd = 1'b1;
        wait_sig(0, 1'b0, 10, n);
        short_cmd = 1'b0;
        chk("blank_start", 1'b0, rampup_done_out);
        wait_sig(0, 1'b1, 30, n);
        chk_rng("blank_low", cyc(`FPS_BLANK_LATCH_MS) - 1,
                cyc(`FPS_BLANK_LATCH_MS) + 6, n);
        chk("ramp_done_kept", 1'b1, rampup_done_out);
        cycles(cyc(`FPS_RAMP_MS) + 4);
        short_cmd = 1'b1;
        wait_sig(0, 1'b0, 10, n);
        cycles($urandom_range(20, 40));
        chk("blank_extend", 1'b0, switching_enable_out);
        short_cmd = 1'b0;
        wait_sig(0, 1'b1, 8, n);
        cycles(cyc(`FPS_RAMP_MS) + 60);
        chk("decay_run", 1'b1, rampup_done_out);
        for (int i = 1; i <= 10; i++) begin
            short_cmd = 1'b1;
            wait_sig(0, 1'b0, 10, n);
            short_cmd = 1'b0;
            if (i < 10) begin
                chk("count_below", 1'b0, fault_flag_out);
                wait_sig(2, 1'b1, 30, n);
                chk("restart_done", 1'b1, rampup_done_out);
                cycles($urandom_range(10, 60));
            end
        end
        wait_sig(3, 1'b1, 30, n);
        cycles(300);
        chk("latch_flag", 1'b1, fault_flag_out);
        chk("latch_done", 1'b0, rampup_done_out);
        chk("latch_run", 1'b0, switching_enable_out);
        power_up(1'b0);
        wait_sig(1, 1'b1, 130, n);
        oc_low = 1'b1;
        cycles($urandom_range(60, 140));
        oc_low = 1'b0;
        cycles(5);
        chk("oc_low_short", 1'b0, fault_flag_out);
        oc_low = 1'b1;
        wait_sig(3, 1'b1, 170, n);
        chk_rng("oc_low_delay", cyc(`FPS_OC_LOW_MS),
                cyc(`FPS_OC_LOW_MS) + 6, n);
        chk("oc_low_trip", 1'b1, ocp_out);
        power_up(1'b1);
        wait_sig(1, 1'b1, 130, n);
        oc_high = 1'b1;
        cycles($urandom_range(30, 90));
        oc_high = 1'b0;
        cycles(5);
        chk("oc_high_ride", 1'b1, switching_enable_out);
        oc_high = 1'b1;
        wait_sig(0, 1'b0, 130, n);
        chk_rng("oc_high_delay", cyc(`FPS_OC_HIGH_MS),
                cyc(`FPS_OC_HIGH_MS) + 6, n);
        chk("oc_high_trip", 1'b1, ocp_out);
        oc_high = 1'b0;
        chk("hiccup_flag", 1'b0, fault_flag_out);
        chk("hiccup_done", 1'b0, rampup_done_out);
        wait_sig(0, 1'b1, 4900, n);
        chk_rng("hiccup_low", cyc(`FPS_HICCUP_MS) - 1,
                cyc(`FPS_HICCUP_MS) + 6, n);
        cycles(cyc(`FPS_RAMP_MS) + 4);
        chk("hiccup_ramp", 1'b1, rampup_done_out);
        for (int i = 0; i < 11; i++) begin
            short_cmd = 1'b1;
            wait_sig(0, 1'b0, 10, n);
            short_cmd = 1'b0;
            wait_sig(0, 1'b1, 4900, n);
            chk_rng("retry_low", cyc(`FPS_HICCUP_MS) - 1,
                    cyc(`FPS_HICCUP_MS) + 6, n);
            chk("retry_flag", 1'b0, fault_flag_out);
            cycles(20);
        end
        short_cmd = 1'b1;
        wait_sig(0, 1'b0, 10, n);
        short_cmd = 1'b0;
        bus_ov = 1'b1;
        wait_sig(3, 1'b1, 10, n);
        chk("ov_seen", 1'b1, ovp_out);
        test_done();
    end
endmodule
`default_nettype wire
